// File: test/lpsc_link_partner.sv
module lpsc_link_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic go_enter,
  input wire logic [3:0] ack_delay,
  input wire logic send_pm_enter_l1,
  input wire logic send_aspm_l1_req,
  input wire logic send_pm_req_ack,
  output logic rx_pm_enter_l1,
  output logic rx_pm_req_ack,
  output logic rx_elec_idle
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt;
  int rep_cnt;
  logic enter_active;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 0;
      rep_cnt <= 0;
      enter_active <= 1'b0;
      rx_pm_enter_l1 <= 1'b0;
      rx_pm_req_ack <= 1'b0;
      rx_elec_idle <= 1'b0;
    end else begin
      rx_pm_req_ack <= 1'b0;
      rx_pm_enter_l1 <= 1'b0;
      // slow answers: repeats arriving while a reply is pending are ignored
      if ((send_pm_enter_l1 || send_aspm_l1_req) && wait_cnt == 0) begin
        wait_cnt <= int'(ack_delay) + 1;
      end else if (wait_cnt == 1) begin
        rx_pm_req_ack <= 1'b1;
        wait_cnt <= 0;
      end else if (wait_cnt > 1) begin
        wait_cnt <= wait_cnt - 1;
      end
      if (go_enter && !enter_active && !rx_elec_idle) begin
        enter_active <= 1'b1;
        rep_cnt <= 0;
      end
      if (enter_active) begin
        if (send_pm_req_ack) begin
          enter_active <= 1'b0;
          rx_elec_idle <= 1'b1;
        end else begin
          rep_cnt <= (rep_cnt == 7) ? 0 : rep_cnt + 1;
          rx_pm_enter_l1 <= (rep_cnt == 0);
        end
      end
      if (!go_enter) begin
        rx_elec_idle <= 1'b0;
      end
    end
  end
endmodule : lpsc_link_partner

// File: test/test_link_power_state_control.sv
module test_link_power_state_control;
  timeunit 1ns;
  timeprecision 1ns;
  import lpsc_pkg::*;
  logic sys_clk, rst, wr_stb, rd_stb, up, ep, l0s_en, l1_en, l1ss_en, sw_en, gen2;
  logic tlp_pend, ak_pend, in_prog, rep_empty, go_enter, rx_enter, rx_ack, rx_eidle;
  logic send_enter, send_ack, send_eios;
  logic [7:0] addr, fts, fts_out, ev;
  logic [5:0] pl;
  logic [31:0] wdata, rdata, d;
  logic [15:0] t_l0s, t_l1, t_ext;
  logic [2:0] c0, c1, e0, e1;
  logic [3:0] ack_dly, pm_state;
  int unsigned seed = 80;
  int unsigned r;
  int n, m, me, ma, fail_count, n_compared, n_enter, n_ack, n_eios, n_areq, n_rej;

  lpsc_top #(.TIMER_W(16)) lpsc_top_inst (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .CFG_UPSTREAM(up), .CFG_ENDPOINT(ep),
    .CFG_L0S_EN(l0s_en), .CFG_ASPM_L1_EN(l1_en), .CFG_L1SS_EN(l1ss_en), .CFG_SW_L1_EN(sw_en),
    .CFG_LINK_GEN2(gen2), .CFG_STANDBY_ENTRY_IDLE_TIME(t_l0s), .CFG_ASPM_L1_IDLE_TIME(t_l1),
    .CFG_FTS_COUNT(fts), .CFG_FAST_TRAIN_TIMEOUT_EXTENSION(t_ext), .CFG_L0S_ACC_LAT(c0),
    .CFG_L1_ACC_LAT(c1), .CFG_L0S_EXIT_LAT(e0), .CFG_L1_EXIT_LAT(e1), .TX_TLP_PENDING(tlp_pend),
    .TX_ACKNAK_PENDING(ak_pend), .TX_IN_PROGRESS(in_prog), .TX_TLP_SENT(pl[0]), .TX_ACKNAK_SENT(pl[1]),
    .TX_DLLP_SENT(pl[5]), .REPLAY_EMPTY(rep_empty), .RX_PM_ENTER_L1(rx_enter), .RX_PM_REQ_ACK(rx_ack),
    .RX_ASPM_L1_REQ(pl[2]), .RX_ASPM_REJECT(1'b0), .RX_ELEC_IDLE(rx_eidle), .LTSSM_L0_REACHED(pl[4]),
    .LTSSM_L1_EXIT_PARTNER(pl[3]), .TX_BLOCK(ev[1]), .TX_ELEC_IDLE(ev[0]), .FTS_COUNT(fts_out),
    .LTSSM_GO_L1(ev[2]), .LTSSM_GO_L0(ev[3]), .LTSSM_GO_RECOVERY(ev[4]), .SEND_PM_ENTER_L1(send_enter),
    .SEND_PM_REQ_ACK(send_ack), .SEND_ASPM_L1_REQ(ev[7]), .SEND_ASPM_REJECT(ev[6]), .SEND_EIOS(send_eios),
    .SEND_MGMT_DLLP(ev[5]), .PM_STATE(pm_state));

  lpsc_link_partner lpsc_link_partner_inst (.clk(sys_clk), .rst(rst), .go_enter(go_enter),
    .ack_delay(ack_dly), .send_pm_enter_l1(send_enter), .send_aspm_l1_req(ev[7]),
    .send_pm_req_ack(send_ack), .rx_pm_enter_l1(rx_enter), .rx_pm_req_ack(rx_ack), .rx_elec_idle(rx_eidle));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    n_enter += int'(send_enter);
    n_ack += int'(send_ack);
    n_eios += int'(send_eios);
    n_areq += int'(ev[7]);
    n_rej += int'(ev[6]);
  end

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    // taken before this edge replaces it, so stimulus stays on the edge
    @(posedge sys_clk);
    v = rdata;
  endtask : rd

  // n ends at lim + 1 when the output never rose
  task automatic wait_hi(input int k, input int lim, output int cnt);
    for (cnt = 1; cnt <= lim; cnt++) begin
      @(posedge sys_clk);
      #1;
      if (ev[k] === 1'b1) break;
    end
  endtask : wait_hi

  task automatic pulse(input int k);
    @(posedge sys_clk);
    pl[k] <= 1'b1;
    @(posedge sys_clk);
    pl[k] <= 1'b0;
  endtask : pulse

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {rst, wr_stb, rd_stb, up, ep, l0s_en, l1_en, l1ss_en, sw_en, gen2} = 10'h200;
    {tlp_pend, ak_pend, in_prog, rep_empty, go_enter} = 5'h02;
    {addr, fts, wdata, pl, ack_dly} = '0;
    {t_l0s, t_l1, t_ext, c0, c1, e0, e1} = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      r = xs();
      {c0, c1, e0, e1} <= r[11:0];
      l0s_en <= k[0];
      l1_en <= k[1];
      l1ss_en <= k[0];
      ep <= (k < 2);
      repeat (2) @(posedge sys_clk);
      rd(OFS_DEV_CAP, d);
      chk(d, ep ? {20'h0, c1, c0, 6'h0} : 32'h0);
      rd(OFS_LINK_CAP, d);
      chk(d, {14'h0, e1, e0, l1_en, l0s_en, 10'h0});
      rd(OFS_STATUS, d);
      chk(d[6], l1ss_en);
    end
    wr(OFS_DEV_CAP, 32'hFFFFFFFF);
    rd(OFS_DEV_CAP, d);
    chk(d, 32'h0);
    rd(8'h40, d);
    chk(d, 32'h0);
    $display("capability test done");
    r = xs();
    {up, ep, l0s_en, l1_en} <= 4'hE;
    fts <= 8'h14;
    t_ext <= 16'h5;
    t_l1 <= 16'hA;
    t_l0s <= 16'h3 + 16'(r[2:0]);
    wr(OFS_CTRL, 32'h4);
    repeat (2) @(posedge sys_clk);
    chk(fts_out, 8'h14);
    pulse(5);
    repeat (t_l0s - 2) @(posedge sys_clk);
    pulse(1);
    wait_hi(0, t_l0s + 4, n);
    chk(n > t_l0s && n <= t_l0s + 2, 1'b1);
    chk(pm_state, 4'h1);
    @(posedge sys_clk);
    tlp_pend <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk(ev[0], 1'b0);
    pulse(4);
    @(posedge sys_clk);
    tlp_pend <= 1'b0;
    #1 chk(pm_state, 4'h0);
    wait_hi(0, t_l0s + 4, n);
    chk(n <= t_l0s + 4, 1'b1);
    @(posedge sys_clk);
    tlp_pend <= 1'b1;
    // 20 sets of 16 ns round up to 4 cycles, plus 5 extension cycles
    wait_hi(4, 14, n);
    chk(n >= 9 && n <= 13, 1'b1);
    @(posedge sys_clk);
    tlp_pend <= 1'b0;
    wait_hi(5, 330, n);
    chk(n <= 330, 1'b1);
    $display("standby test done");
    l0s_en <= 1'b0;
    sw_en <= 1'b1;
    in_prog <= 1'b1;
    rep_empty <= 1'b0;
    ack_dly <= r[7:4];
    m = n_enter;
    wr(OFS_CTRL, 32'h3);
    wait_hi(1, 4, n);
    chk(n <= 4, 1'b1);
    repeat (12) @(posedge sys_clk);
    chk(n_enter - m, 0);
    in_prog <= 1'b0;
    rep_empty <= 1'b1;
    me = n_eios;
    wait_hi(2, 60, n);
    chk(n <= 60 && ev[0] === 1'b1, 1'b1);
    @(posedge sys_clk);
    tlp_pend <= 1'b1;
    // the last idle set is only counted at this edge
    #1 chk(n_eios - me, 1);
    wait_hi(3, 3, n);
    chk(n <= 3 && ev[2] === 1'b0, 1'b1);
    @(posedge sys_clk);
    tlp_pend <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    $display("software L1 test done");
    {up, gen2, in_prog, go_enter} <= 4'h7;
    l1_en <= 1'b1;
    m = n_ack;
    me = n_eios;
    ma = n_areq;
    repeat (20) @(posedge sys_clk);
    chk(n_ack - m, 0);
    in_prog <= 1'b0;
    wait_hi(2, 80, n);
    chk(n <= 80 && n_ack > m, 1'b1);
    @(posedge sys_clk);
    pl[3] <= 1'b1;
    #1 chk(n_eios - me, 2);
    wait_hi(3, 3, n);
    chk(n <= 3, 1'b1);
    @(posedge sys_clk);
    pl[3] <= 1'b0;
    go_enter <= 1'b0;
    wr(OFS_CTRL, 32'h8);
    @(posedge sys_clk);
    ak_pend <= 1'b1;
    m = n_rej;
    pulse(2);
    // the reject pulse stands one cycle only; count it instead of polling
    repeat (2) @(posedge sys_clk);
    #1 chk(n_rej - m, 1);
    m = n_rej;
    @(posedge sys_clk);
    ak_pend <= 1'b0;
    pulse(2);
    repeat (3) @(posedge sys_clk);
    #1 chk(n_rej - m, 0);
    chk(pm_state, 4'h7);
    go_enter <= 1'b1;
    wait_hi(2, 40, n);
    chk(n <= 40, 1'b1);
    @(posedge sys_clk);
    tlp_pend <= 1'b1;
    go_enter <= 1'b0;
    repeat (2) @(posedge sys_clk);
    tlp_pend <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk(n_areq - ma, 0);
    $display("downstream test done");
    up <= 1'b1;
    wr(OFS_CTRL, 32'h0);
    repeat (30) @(posedge sys_clk);
    chk(n_areq - ma, 0);
    wr(OFS_CTRL, 32'h8);
    pulse(0);
    wait_hi(7, t_l1 + 8, n);
    chk(n > t_l1 && n <= t_l1 + 8, 1'b1);
    wait_hi(2, 40, n);
    chk(n <= 40, 1'b1);
    @(posedge sys_clk);
    tlp_pend <= 1'b1;
    wait_hi(3, 3, n);
    chk(n <= 3, 1'b1);
    @(posedge sys_clk);
    tlp_pend <= 1'b0;
    $display("autonomous L1 test done");
    tally_and_finish();
  end
endmodule : test_link_power_state_control

// File: verilog/lpsc_pkg.sv
package lpsc_pkg;

  // register map, byte addresses on the plain register port
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_DEV_CAP = 8'h00;
  localparam logic [7:0] OFS_LINK_CAP = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // capability field positions
  localparam int DEVCAP_L0S_ACC_LSB = 6;
  localparam int DEVCAP_L1_ACC_LSB = 9;
  localparam int LINKCAP_ASPM_LSB = 10;
  localparam int LINKCAP_L0S_EXIT_LSB = 12;
  localparam int LINKCAP_L1_EXIT_LSB = 15;

  // control word fields
  localparam int CTRL_PSTATE_LSB = 0;
  localparam int CTRL_L0S_BIT = 2;
  localparam int CTRL_L1_BIT = 3;
  localparam logic [1:0] PSTATE_D0 = 2'h0;
  localparam logic [1:0] CTRL_PSTATE_RST = 2'h0;
  localparam logic CTRL_ASPM_RST = 1'b0;

  // status word fields
  localparam int STAT_EIDLE_BIT = 4;
  localparam int STAT_BLOCK_BIT = 5;
  localparam int STAT_L1SS_BIT = 6;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int FTS_TIME_NS = 16;
  localparam int MGMT_DLLP_PERIOD_NS = 30000;
  localparam int MGMT_DLLP_PERIOD_CYC = MGMT_DLLP_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PM_DLLP_REPEAT_NS = 800;
  localparam int PM_DLLP_REPEAT_CYC = PM_DLLP_REPEAT_NS / CLK_PERIOD_NS;
  localparam logic [1:0] EIOS_COUNT_GEN1 = 2'h1;
  localparam logic [1:0] EIOS_COUNT_GEN2 = 2'h2;

  typedef enum logic [3:0] {
    ST_L0,
    ST_L0S,
    ST_L0S_EXIT,
    ST_SW_DRAIN,
    ST_SW_ENTER,
    ST_ASPM_REQ,
    ST_DS_DRAIN,
    ST_DS_ACK,
    ST_EIOS,
    ST_L1
  } lpsc_pm_state_t;

endpackage : lpsc_pkg

// File: verilog/lpsc_top.sv
// What this block does
// (R1) L0/off fixed; other states enabled by configuration
// (R2) idle transmitter enters L0s, pending data exits
// (R3) periodic link management DLLPs force L0s exits
// (R4) L0s entry waits configured idle interval
// (R5) fast training count taken from configuration
// (R6) late L0s exit directs link to Recovery
// (R7) L0s acceptable latency in device capabilities
// (R8) non-Endpoint acceptable latency fields read zero
// (R9) L0s exit latency in link capabilities
// (R10) ASPM support bits follow L0s/L1 enables
// (R11) non-D0 state blocks packets, drains replay buffer
// (R12) repeat enter-L1 until acknowledged, then L1
// (R13) pending packet or partner activity leaves L1
// (R14) downstream drains, repeats ack until partner idles
// (R15) L1 acceptable latency in device capabilities
// (R16) L1 exit latency in link capabilities
// (R17) only Upstream Port requests ASPM L1
// (R18) ASPM L1 needs feature and software enable
// (R19) upstream requests L1 after configured idle period
// (R20) downstream accepts ASPM L1 only when nothing pending
// (R21) downstream sends 1/2 idle sets, then idles
// (R22) idle timers restart on each packet/ack-nak
module lpsc_top #(
  parameter int TIMER_W = 16
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [lpsc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [31:0] RDATA,
  input wire logic CFG_UPSTREAM,
  input wire logic CFG_ENDPOINT,
  input wire logic CFG_L0S_EN,
  input wire logic CFG_ASPM_L1_EN,
  input wire logic CFG_L1SS_EN,
  input wire logic CFG_SW_L1_EN,
  input wire logic CFG_LINK_GEN2,
  input wire logic [TIMER_W-1:0] CFG_STANDBY_ENTRY_IDLE_TIME,
  input wire logic [TIMER_W-1:0] CFG_ASPM_L1_IDLE_TIME,
  input wire logic [7:0] CFG_FTS_COUNT,
  input wire logic [TIMER_W-1:0] CFG_FAST_TRAIN_TIMEOUT_EXTENSION,
  input wire logic [2:0] CFG_L0S_ACC_LAT,
  input wire logic [2:0] CFG_L1_ACC_LAT,
  input wire logic [2:0] CFG_L0S_EXIT_LAT,
  input wire logic [2:0] CFG_L1_EXIT_LAT,
  input wire logic TX_TLP_PENDING,
  input wire logic TX_ACKNAK_PENDING,
  input wire logic TX_IN_PROGRESS,
  input wire logic TX_TLP_SENT,
  input wire logic TX_ACKNAK_SENT,
  input wire logic TX_DLLP_SENT,
  input wire logic REPLAY_EMPTY,
  input wire logic RX_PM_ENTER_L1,
  input wire logic RX_PM_REQ_ACK,
  input wire logic RX_ASPM_L1_REQ,
  input wire logic RX_ASPM_REJECT,
  input wire logic RX_ELEC_IDLE,
  input wire logic LTSSM_L0_REACHED,
  input wire logic LTSSM_L1_EXIT_PARTNER,
  output logic TX_BLOCK,
  output logic TX_ELEC_IDLE,
  output logic [7:0] FTS_COUNT,
  output logic LTSSM_GO_L1,
  output logic LTSSM_GO_L0,
  output logic LTSSM_GO_RECOVERY,
  output logic SEND_PM_ENTER_L1,
  output logic SEND_PM_REQ_ACK,
  output logic SEND_ASPM_L1_REQ,
  output logic SEND_ASPM_REJECT,
  output logic SEND_EIOS,
  output logic SEND_MGMT_DLLP,
  output logic [3:0] PM_STATE
);
  import lpsc_pkg::*;

  if (TIMER_W < 4 || TIMER_W > 24) begin : g_bad_width
    $error("TIMER_W must lie between 4 and 24");
  end

  localparam logic [15:0] MGMT_LAST = 16'(MGMT_DLLP_PERIOD_CYC - 1);
  localparam logic [3:0] REPEAT_LAST = 4'(PM_DLLP_REPEAT_CYC - 1);

  typedef struct packed {
    lpsc_pm_state_t state;
    logic [1:0] ctrl_pstate;
    logic ctrl_l0s;
    logic ctrl_l1;
    logic [1:0] pstate_prev;
    logic [TIMER_W-1:0] l0s_cnt;
    logic [TIMER_W-1:0] l1_cnt;
    logic [TIMER_W:0] exit_cnt;
    logic [3:0] rep_cnt;
    logic [1:0] eios_left;
    logic [15:0] mgmt_cnt;
    logic mgmt_due;
    logic rx_ei_s1;
    logic rx_ei_s2;
    logic [31:0] rdata;
    logic [7:0] fts_count;
    logic tx_block;
    logic tx_eidle;
    logic go_l1;
    logic go_l0;
    logic go_recov;
    logic send_enter;
    logic send_ack;
    logic send_aspm_req;
    logic send_reject;
    logic send_eios;
    logic send_mgmt;
  } lpsc_regs_t;

  lpsc_regs_t st_r;
  lpsc_regs_t st_nxt;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic drained(input logic in_prog, input logic replay_empty);
    drained = !in_prog && replay_empty;
  endfunction : drained

  // fts train time in cycles, rounded up; at 2.5 Gb/s several sets fit in one cycle
  function automatic logic [TIMER_W:0] exit_limit(input logic [7:0] fts, input logic [TIMER_W-1:0] ext);
    logic [31:0] base;
    base = (32'(fts) * 32'(FTS_TIME_NS) + 32'(CLK_PERIOD_NS - 1)) / 32'(CLK_PERIOD_NS);
    exit_limit = (TIMER_W + 1)'(base) + {1'b0, ext};
  endfunction : exit_limit

  logic l0s_ok;
  logic aspm_ok;
  logic l0s_act;
  logic l1_act;
  logic pst_change;
  logic rep_fire;
  logic mgmt_set;
  logic mgmt_clr;
  logic [31:0] dev_cap;
  logic [31:0] link_cap;

  always_comb begin
    l0s_ok = CFG_L0S_EN && st_r.ctrl_l0s; // [R1] [R2]
    aspm_ok = CFG_ASPM_L1_EN && st_r.ctrl_l1; // [R18]
    l0s_act = TX_TLP_SENT || TX_DLLP_SENT || TX_ACKNAK_SENT; // [R4] [R22]
    l1_act = TX_TLP_SENT || TX_ACKNAK_SENT; // [R22]
    pst_change = (st_r.ctrl_pstate != PSTATE_D0) && (st_r.pstate_prev == PSTATE_D0); // [R11]
    rep_fire = (st_r.rep_cnt == 4'h0);
    mgmt_set = (st_r.mgmt_cnt == MGMT_LAST);
    mgmt_clr = 1'b0;
    dev_cap = 32'h0;
    link_cap = 32'h0;
    if (CFG_ENDPOINT) begin // [R8]
      dev_cap[DEVCAP_L0S_ACC_LSB +: 3] = CFG_L0S_ACC_LAT; // [R7]
      dev_cap[DEVCAP_L1_ACC_LSB +: 3] = CFG_L1_ACC_LAT; // [R15]
    end
    link_cap[LINKCAP_ASPM_LSB +: 2] = {CFG_ASPM_L1_EN, CFG_L0S_EN}; // [R10]
    link_cap[LINKCAP_L0S_EXIT_LSB +: 3] = CFG_L0S_EXIT_LAT; // [R9]
    link_cap[LINKCAP_L1_EXIT_LSB +: 3] = CFG_L1_EXIT_LAT; // [R16]

    st_nxt = st_r;
    st_nxt.go_l0 = 1'b0;
    st_nxt.go_recov = 1'b0;
    st_nxt.send_enter = 1'b0;
    st_nxt.send_ack = 1'b0;
    st_nxt.send_aspm_req = 1'b0;
    st_nxt.send_reject = 1'b0;
    st_nxt.send_eios = 1'b0;
    st_nxt.send_mgmt = 1'b0;
    st_nxt.rx_ei_s1 = RX_ELEC_IDLE;
    st_nxt.rx_ei_s2 = st_r.rx_ei_s1;
    st_nxt.fts_count = CFG_FTS_COUNT; // [R5]
    st_nxt.pstate_prev = st_r.ctrl_pstate;
    st_nxt.rep_cnt = (st_r.rep_cnt == REPEAT_LAST) ? 4'h0 : st_r.rep_cnt + 4'h1;

    if (WR_STB && hit(ADDR, OFS_CTRL)) begin
      st_nxt.ctrl_pstate = WDATA[CTRL_PSTATE_LSB +: 2];
      st_nxt.ctrl_l0s = WDATA[CTRL_L0S_BIT];
      st_nxt.ctrl_l1 = WDATA[CTRL_L1_BIT];
    end
    // read data only stand in the cycle after the strobe
    st_nxt.rdata = 32'h0;
    if (RD_STB) begin
      if (hit(ADDR, OFS_DEV_CAP)) begin
        st_nxt.rdata = dev_cap;
      end else if (hit(ADDR, OFS_LINK_CAP)) begin
        st_nxt.rdata = link_cap;
      end else if (hit(ADDR, OFS_CTRL)) begin
        st_nxt.rdata = {28'h0, st_r.ctrl_l1, st_r.ctrl_l0s, st_r.ctrl_pstate};
      end else if (hit(ADDR, OFS_STATUS)) begin
        st_nxt.rdata[3:0] = st_r.state;
        st_nxt.rdata[STAT_EIDLE_BIT] = st_r.tx_eidle;
        st_nxt.rdata[STAT_BLOCK_BIT] = st_r.tx_block;
        st_nxt.rdata[STAT_L1SS_BIT] = CFG_L1SS_EN;
      end
    end

    st_nxt.mgmt_cnt = mgmt_set ? 16'h0 : st_r.mgmt_cnt + 16'h1; // [R3]

    if (l0s_act || st_r.state != ST_L0 || !l0s_ok) begin // [R4]
      st_nxt.l0s_cnt = '0;
    end else if (st_r.l0s_cnt != CFG_STANDBY_ENTRY_IDLE_TIME) begin
      st_nxt.l0s_cnt = st_r.l0s_cnt + 1'b1;
    end
    if (l1_act || st_r.state != ST_L0 || !aspm_ok || !CFG_UPSTREAM) begin // [R22]
      st_nxt.l1_cnt = '0;
    end else if (st_r.l1_cnt != CFG_ASPM_L1_IDLE_TIME) begin
      st_nxt.l1_cnt = st_r.l1_cnt + 1'b1;
    end

    case (st_r.state)
      ST_L0: begin
        if (CFG_UPSTREAM && CFG_SW_L1_EN && pst_change) begin // [R11]
          st_nxt.state = ST_SW_DRAIN;
          st_nxt.tx_block = 1'b1;
        end else if (!CFG_UPSTREAM && CFG_SW_L1_EN && RX_PM_ENTER_L1) begin // [R14]
          st_nxt.state = ST_DS_DRAIN;
          st_nxt.tx_block = 1'b1;
        end else if (!CFG_UPSTREAM && RX_ASPM_L1_REQ) begin
          if (aspm_ok && !TX_TLP_PENDING && !TX_ACKNAK_PENDING) begin // [R20] [R18]
            st_nxt.state = ST_DS_ACK;
            st_nxt.tx_block = 1'b1;
            st_nxt.rep_cnt = 4'h0;
          end else begin
            st_nxt.send_reject = 1'b1; // [R20]
          end
        end else if (CFG_UPSTREAM && aspm_ok && !l1_act && !TX_TLP_PENDING
                     && st_r.l1_cnt == CFG_ASPM_L1_IDLE_TIME) begin // [R17] [R19]
          st_nxt.state = ST_ASPM_REQ;
          st_nxt.tx_block = 1'b1;
          st_nxt.rep_cnt = 4'h0;
        end else if (l0s_ok && !l0s_act && !TX_TLP_PENDING && !TX_ACKNAK_PENDING && !st_r.mgmt_due
                     && st_r.l0s_cnt == CFG_STANDBY_ENTRY_IDLE_TIME) begin // [R2] [R4]
          st_nxt.state = ST_L0S;
          st_nxt.tx_eidle = 1'b1;
        end else if (st_r.mgmt_due) begin // [R3]
          st_nxt.send_mgmt = 1'b1;
          mgmt_clr = 1'b1;
        end
      end
      ST_L0S: begin
        // management due forces the exit so the idle link still carries them
        if (TX_TLP_PENDING || TX_ACKNAK_PENDING || st_r.mgmt_due || !l0s_ok) begin // [R2] [R3]
          st_nxt.state = ST_L0S_EXIT;
          st_nxt.tx_eidle = 1'b0;
          st_nxt.exit_cnt = '0;
        end
      end
      ST_L0S_EXIT: begin
        if (LTSSM_L0_REACHED) begin
          st_nxt.state = ST_L0;
        end else if (st_r.exit_cnt >= exit_limit(CFG_FTS_COUNT, CFG_FAST_TRAIN_TIMEOUT_EXTENSION)) begin // [R6]
          st_nxt.go_recov = 1'b1;
          st_nxt.state = ST_L0;
        end else begin
          st_nxt.exit_cnt = st_r.exit_cnt + 1'b1;
        end
      end
      ST_SW_DRAIN: begin
        if (drained(TX_IN_PROGRESS, REPLAY_EMPTY)) begin // [R11]
          st_nxt.state = ST_SW_ENTER;
          st_nxt.rep_cnt = 4'h0;
        end
      end
      ST_SW_ENTER: begin
        if (RX_PM_REQ_ACK) begin // [R12]
          st_nxt.state = ST_EIOS;
          st_nxt.eios_left = CFG_LINK_GEN2 ? EIOS_COUNT_GEN2 : EIOS_COUNT_GEN1;
        end else begin
          st_nxt.send_enter = rep_fire; // [R12]
        end
      end
      ST_ASPM_REQ: begin
        if (RX_ASPM_REJECT || TX_TLP_PENDING) begin
          st_nxt.state = ST_L0;
          st_nxt.tx_block = 1'b0;
        end else if (RX_PM_REQ_ACK) begin
          st_nxt.state = ST_EIOS;
          st_nxt.eios_left = CFG_LINK_GEN2 ? EIOS_COUNT_GEN2 : EIOS_COUNT_GEN1;
        end else if (drained(TX_IN_PROGRESS, REPLAY_EMPTY)) begin
          st_nxt.send_aspm_req = rep_fire; // [R19]
        end
      end
      ST_DS_DRAIN: begin
        if (drained(TX_IN_PROGRESS, REPLAY_EMPTY)) begin // [R14]
          st_nxt.state = ST_DS_ACK;
          st_nxt.rep_cnt = 4'h0;
        end
      end
      ST_DS_ACK: begin
        if (st_r.rx_ei_s2) begin // [R14] [R21]
          st_nxt.state = ST_EIOS;
          st_nxt.eios_left = CFG_LINK_GEN2 ? EIOS_COUNT_GEN2 : EIOS_COUNT_GEN1;
        end else begin
          st_nxt.send_ack = rep_fire; // [R14]
        end
      end
      ST_EIOS: begin
        st_nxt.send_eios = 1'b1; // [R21]
        st_nxt.eios_left = st_r.eios_left - 2'h1;
        if (st_r.eios_left == 2'h1) begin
          st_nxt.state = ST_L1;
          st_nxt.tx_eidle = 1'b1;
          st_nxt.go_l1 = 1'b1; // [R12]
        end
      end
      ST_L1: begin
        if (TX_TLP_PENDING || LTSSM_L1_EXIT_PARTNER) begin // [R13]
          st_nxt.state = ST_L0;
          st_nxt.tx_eidle = 1'b0;
          st_nxt.tx_block = 1'b0;
          st_nxt.go_l1 = 1'b0;
          st_nxt.go_l0 = 1'b1;
        end
      end
      default: begin
        st_nxt.state = ST_L0;
        st_nxt.tx_eidle = 1'b0;
        st_nxt.tx_block = 1'b0;
        st_nxt.go_l1 = 1'b0;
      end
    endcase
    // a new period wins over the issue in the same cycle
    st_nxt.mgmt_due = mgmt_set || (st_r.mgmt_due && !mgmt_clr); // [R3]
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA = st_r.rdata;
  assign TX_BLOCK = st_r.tx_block;
  assign TX_ELEC_IDLE = st_r.tx_eidle;
  assign FTS_COUNT = st_r.fts_count;
  assign LTSSM_GO_L1 = st_r.go_l1;
  assign LTSSM_GO_L0 = st_r.go_l0;
  assign LTSSM_GO_RECOVERY = st_r.go_recov;
  assign SEND_PM_ENTER_L1 = st_r.send_enter;
  assign SEND_PM_REQ_ACK = st_r.send_ack;
  assign SEND_ASPM_L1_REQ = st_r.send_aspm_req;
  assign SEND_ASPM_REJECT = st_r.send_reject;
  assign SEND_EIOS = st_r.send_eios;
  assign SEND_MGMT_DLLP = st_r.send_mgmt;
  assign PM_STATE = st_r.state;

  chk_l0s_needs_enable: assert property (@(posedge SYS_CLK) disable iff (RST) // [R2]
    $rose(st_r.tx_eidle) && st_r.state == ST_L0S |-> $past(CFG_L0S_EN) && $past(st_r.ctrl_l0s))
    else $error("L0s entered while not enabled");

  chk_l0s_full_idle: assert property (@(posedge SYS_CLK) disable iff (RST) // [R4]
    $rose(st_r.tx_eidle) && st_r.state == ST_L0S
    |-> $past(st_r.l0s_cnt) == $past(CFG_STANDBY_ENTRY_IDLE_TIME) && !$past(TX_TLP_SENT))
    else $error("L0s entered before the idle interval ran out");

  chk_l0s_exit_pend: assert property (@(posedge SYS_CLK) disable iff (RST) // [R2]
    st_r.state == ST_L0S && TX_TLP_PENDING |=> st_r.state == ST_L0S_EXIT && !st_r.tx_eidle)
    else $error("pending packet did not end L0s");

  chk_recovery_late: assert property (@(posedge SYS_CLK) disable iff (RST) // [R6]
    st_r.go_recov |-> $past(st_r.state) == ST_L0S_EXIT && !$past(LTSSM_L0_REACHED))
    else $error("recovery directed outside a late L0s exit");

  chk_block_non_d0: assert property (@(posedge SYS_CLK) disable iff (RST) // [R11]
    st_r.state == ST_L0 && CFG_UPSTREAM && CFG_SW_L1_EN && pst_change |=> st_r.tx_block ##0 st_r.state == ST_SW_DRAIN)
    else $error("non-D0 power state did not block packets");

  chk_enter_until_ack: assert property (@(posedge SYS_CLK) disable iff (RST) // [R12]
    st_r.state == ST_SW_ENTER && RX_PM_REQ_ACK |=> st_r.state == ST_EIOS ##[1:2] st_r.go_l1)
    else $error("acknowledge did not lead to L1");

  chk_l1_leave: assert property (@(posedge SYS_CLK) disable iff (RST) // [R13]
    st_r.state == ST_L1 && (TX_TLP_PENDING || LTSSM_L1_EXIT_PARTNER) |=> st_r.state == ST_L0 && st_r.go_l0)
    else $error("L1 not left on activity");

  chk_ds_never_requests: assert property (@(posedge SYS_CLK) disable iff (RST) // [R17]
    st_r.send_aspm_req |-> $past(CFG_UPSTREAM))
    else $error("downstream port sent an ASPM L1 request");

  chk_aspm_reject: assert property (@(posedge SYS_CLK) disable iff (RST) // [R20]
    st_r.state == ST_L0 && !CFG_UPSTREAM && RX_ASPM_L1_REQ && !(CFG_SW_L1_EN && RX_PM_ENTER_L1)
    && (TX_TLP_PENDING || TX_ACKNAK_PENDING) |=> st_r.send_reject && st_r.state == ST_L0)
    else $error("ASPM L1 request not rejected with traffic pending");

  chk_devcap_zero: assert property (@(posedge SYS_CLK) disable iff (RST) // [R8]
    RD_STB && hit(ADDR, OFS_DEV_CAP) && !CFG_ENDPOINT |=> st_r.rdata[11:6] == 6'h00)
    else $error("acceptable latency fields not zero for non-endpoint");

  chk_aspm_field: assert property (@(posedge SYS_CLK) disable iff (RST) // [R10]
    RD_STB && hit(ADDR, OFS_LINK_CAP) |=> st_r.rdata[11:10] == {$past(CFG_ASPM_L1_EN), $past(CFG_L0S_EN)})
    else $error("ASPM support field wrong");

  chk_eios_count: assert property (@(posedge SYS_CLK) disable iff (RST) // [R21]
    $rose(st_r.state == ST_EIOS) && !CFG_LINK_GEN2 |=> st_r.send_eios ##1 !st_r.send_eios && st_r.tx_eidle)
    else $error("wrong number of idle sets before idling");

endmodule : lpsc_top
